// >>> rtl/ict_defs.vh
// Purpose: Constants for the instruction cycle timing sequencer
// Assumes: Included by bare name from rtl files
// Notes: Definitions only
`ifndef ICT_DEFS_VH
`define ICT_DEFS_VH

// ----------------------------------------
// Instruction classes
// ----------------------------------------
`define ICT_OPW 4
`define ICT_OP_ADD_B_IMM 4'h0
`define ICT_OP_ADD_B_REG 4'h1
`define ICT_OP_ADD_W_REG 4'h2
`define ICT_OP_INCREMENT_BY_CONST 4'h3
`define ICT_OP_SUM_WITH_CARRY_IMM 4'h4
`define ICT_OP_SUM_WITH_CARRY_REG 4'h5
`define ICT_OP_AND_IMM 4'h6
`define ICT_OP_AND_REG 4'h7
`define ICT_OP_FLAGS_CONJUNCTION 4'h8
`define ICT_OP_BIT_AND_REG 4'h9
`define ICT_OP_BIT_AND_MEM 4'ha
`define ICT_OP_BRANCH_SHORT 4'hb
`define ICT_OP_BIT_CLEAR_REG 4'hc
`define ICT_OP_BIT_CLEAR_MEM 4'hd

// ----------------------------------------
// Access locations
// ----------------------------------------
`define ICT_LOC_ONCHIP_MEM 2'h0
`define ICT_LOC_REG_FIELD 2'h1
`define ICT_LOC_EXTERNAL 2'h2

// ----------------------------------------
// Cycle kinds
// ----------------------------------------
`define ICT_KIND_FETCH 3'h0
`define ICT_KIND_BRANCH_ADDR 3'h1
`define ICT_KIND_STACK 3'h2
`define ICT_KIND_BYTE 3'h3
`define ICT_KIND_WORD 3'h4
`define ICT_KIND_INTERNAL 3'h5

// ----------------------------------------
// State costs per cycle
// ----------------------------------------
`define ICT_WAITW 4
`define ICT_COSTW 6
`define ICT_COST_FETCH_ONCHIP 6'h02
`define ICT_COST_FETCH_REG 6'h06
`define ICT_COST_FETCH_EXT 6'h06
`define ICT_COST_BYTE_REG 6'h03
`define ICT_COST_BYTE_EXT 6'h03
`define ICT_COST_WORD_REG 6'h06
`define ICT_COST_WORD_EXT 6'h06
`define ICT_COST_INTERNAL 6'h01

// ----------------------------------------
// Cycle count fields
// ----------------------------------------
`define ICT_CNTW 3
`define ICT_TOTW 9
`define ICT_KINDS 6
`define ICT_CNT_NONE 3'h0
`define ICT_CNT_ONE 3'h1
`define ICT_CNT_TWO 3'h2
`define ICT_STATE_ONE 6'h01
`define ICT_COST_ZERO 6'h00
`define ICT_TOT_ONE 9'h001
`define ICT_TOT_ZERO 9'h000

`endif

// >>> rtl/ict_cycle_cost.v
// Purpose: State cost of one bus or internal cycle
// Assumes: Wait count applies per external byte transfer
// Notes: Purely combinational
`timescale 1ns/1ps
`include "ict_defs.vh"

module ict_cycle_cost (
  // Cycle description
  input wire [2:0] kind,
  input wire [1:0] loc,
  input wire [`ICT_WAITW-1:0] wait_count,
  // Result
  output reg [`ICT_COSTW-1:0] cost
);

  wire [`ICT_COSTW-1:0] wait_once;
  wire [`ICT_COSTW-1:0] wait_twice;

  // Word-wide external transfers are two byte transfers
  assign wait_once = {{(`ICT_COSTW-`ICT_WAITW){1'b0}}, wait_count};
  assign wait_twice = {wait_once[`ICT_COSTW-2:0], 1'b0};

  always @* begin
    cost = `ICT_COST_INTERNAL;
    case (kind)
      `ICT_KIND_FETCH, `ICT_KIND_BRANCH_ADDR, `ICT_KIND_STACK: begin
        case (loc)
          `ICT_LOC_ONCHIP_MEM: cost = `ICT_COST_FETCH_ONCHIP;
          `ICT_LOC_REG_FIELD: cost = `ICT_COST_FETCH_REG;
          default: cost = `ICT_COST_FETCH_EXT + wait_twice;
        endcase
      end
      // On-chip memory has no data access figure; treated as register field
      `ICT_KIND_BYTE: begin
        if (loc == `ICT_LOC_EXTERNAL) begin
          cost = `ICT_COST_BYTE_EXT + wait_once;
        end else begin
          cost = `ICT_COST_BYTE_REG;
        end
      end
      `ICT_KIND_WORD: begin
        if (loc == `ICT_LOC_EXTERNAL) begin
          cost = `ICT_COST_WORD_EXT + wait_twice;
        end else begin
          cost = `ICT_COST_WORD_REG;
        end
      end
      default: cost = `ICT_COST_INTERNAL;
    endcase
  end

endmodule

// >>> rtl/ict_sequencer.v
// Purpose: Instruction execution timing sequencer
// Assumes: One instruction accepted at a time; locations held by caller during it
// Notes: Walks the cycle kinds in order, spending each cycle's state cost
`timescale 1ns/1ps
`include "ict_defs.vh"

// Operation
// - Instruction takes sum of cycle counts times per-cycle state cost.
// - Fetch, branch read, stack: 2 on-chip, 6 register field, 6+2m external.
// - Byte access 3 or 3+m; word access 6 or 6+2m.
// - Internal operation cycle always costs one state.
// - Wait count stretches once per byte, twice per word transfer.
// - Simple add, carry add, increment, AND, flags AND, register bit ops: one fetch.
// - Short branches, taken or not, take exactly two fetch cycles.
// - Memory bit AND: two fetches, one byte; bit clear: two fetches, two bytes.
module ict_sequencer (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Instruction request
  input wire start,
  input wire [`ICT_OPW-1:0] op_class,
  input wire [1:0] fetch_loc,
  input wire [1:0] data_loc,
  input wire [1:0] stack_loc,
  input wire [`ICT_WAITW-1:0] wait_count,
  // Status
  output wire ready,
  output reg done,
  output reg [2:0] cycle_kind,
  output reg cycle_start,
  output reg busy,
  output reg [`ICT_TOTW-1:0] total_states,
  output reg [`ICT_TOTW-1:0] elapsed_states
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_PICK = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // ----------------------------------------
  // State, counters and cycle selection
  // ----------------------------------------
  reg [2:0] state;
  wire [`ICT_CNTW-1:0] left_fetch;
  wire [`ICT_CNTW-1:0] left_branch;
  wire [`ICT_CNTW-1:0] left_stack;
  wire [`ICT_CNTW-1:0] left_byte;
  wire [`ICT_CNTW-1:0] left_word;
  wire [`ICT_CNTW-1:0] left_internal;
  reg [`ICT_COSTW-1:0] state_left;
  reg [`ICT_TOTW-1:0] acc;
  reg [1:0] next_loc;
  reg [2:0] next_kind;
  reg any_left;
  reg [`ICT_CNTW-1:0] n_fetch;
  reg [`ICT_CNTW-1:0] n_byte;
  wire [`ICT_COSTW-1:0] cost;
  wire [`ICT_TOTW-1:0] cost_wide;
  wire [`ICT_KINDS-1:0] pick_hot;
  wire [`ICT_CNTW*`ICT_KINDS-1:0] load_flat;
  wire [`ICT_CNTW*`ICT_KINDS-1:0] left_flat;
  genvar g;

  assign ready = (state == ST_IDLE);

  // ----------------------------------------
  // Counter views per kind
  // ----------------------------------------
  assign left_fetch = left_flat[`ICT_KIND_FETCH*`ICT_CNTW +: `ICT_CNTW];
  assign left_branch = left_flat[`ICT_KIND_BRANCH_ADDR*`ICT_CNTW +: `ICT_CNTW];
  assign left_stack = left_flat[`ICT_KIND_STACK*`ICT_CNTW +: `ICT_CNTW];
  assign left_byte = left_flat[`ICT_KIND_BYTE*`ICT_CNTW +: `ICT_CNTW];
  assign left_word = left_flat[`ICT_KIND_WORD*`ICT_CNTW +: `ICT_CNTW];
  assign left_internal = left_flat[`ICT_KIND_INTERNAL*`ICT_CNTW +: `ICT_CNTW];
  assign pick_hot = {{(`ICT_KINDS-1){1'b0}}, 1'b1} << next_kind;
  // Listed classes use no branch, stack, word or internal cycles
  assign load_flat = {`ICT_CNT_NONE, `ICT_CNT_NONE, n_byte, `ICT_CNT_NONE, `ICT_CNT_NONE, n_fetch};
  assign cost_wide = {{(`ICT_TOTW-`ICT_COSTW){1'b0}}, cost};

  // ----------------------------------------
  // Cycle counts per instruction class
  // ----------------------------------------
  always @* begin
    n_fetch = `ICT_CNT_ONE;
    n_byte = `ICT_CNT_NONE;
    case (op_class)
      `ICT_OP_ADD_B_IMM, `ICT_OP_ADD_B_REG, `ICT_OP_ADD_W_REG, `ICT_OP_INCREMENT_BY_CONST,
      `ICT_OP_SUM_WITH_CARRY_IMM, `ICT_OP_SUM_WITH_CARRY_REG, `ICT_OP_AND_IMM, `ICT_OP_AND_REG,
      `ICT_OP_FLAGS_CONJUNCTION, `ICT_OP_BIT_AND_REG, `ICT_OP_BIT_CLEAR_REG: begin
        n_fetch = `ICT_CNT_ONE;
        n_byte = `ICT_CNT_NONE;
      end
      `ICT_OP_BRANCH_SHORT: begin
        n_fetch = `ICT_CNT_TWO;
      end
      `ICT_OP_BIT_AND_MEM: begin
        n_fetch = `ICT_CNT_TWO;
        n_byte = `ICT_CNT_ONE;
      end
      `ICT_OP_BIT_CLEAR_MEM: begin
        n_fetch = `ICT_CNT_TWO;
        n_byte = `ICT_CNT_TWO;
      end
      default: begin
        // Unassigned class codes run as a single fetch
        n_fetch = `ICT_CNT_ONE;
        n_byte = `ICT_CNT_NONE;
      end
    endcase
  end

  // ----------------------------------------
  // Next cycle kind, in fixed order
  // ----------------------------------------
  always @* begin
    any_left = 1'b1;
    next_kind = `ICT_KIND_FETCH;
    next_loc = fetch_loc;
    if (left_fetch != `ICT_CNT_NONE) begin
      next_kind = `ICT_KIND_FETCH;
      next_loc = fetch_loc;
    end else if (left_branch != `ICT_CNT_NONE) begin
      next_kind = `ICT_KIND_BRANCH_ADDR;
      next_loc = fetch_loc;
    end else if (left_stack != `ICT_CNT_NONE) begin
      next_kind = `ICT_KIND_STACK;
      next_loc = stack_loc;
    end else if (left_byte != `ICT_CNT_NONE) begin
      next_kind = `ICT_KIND_BYTE;
      next_loc = data_loc;
    end else if (left_word != `ICT_CNT_NONE) begin
      next_kind = `ICT_KIND_WORD;
      next_loc = data_loc;
    end else if (left_internal != `ICT_CNT_NONE) begin
      next_kind = `ICT_KIND_INTERNAL;
      next_loc = data_loc;
    end else begin
      any_left = 1'b0;
    end
  end

  ict_cycle_cost u_cost (
    .kind(next_kind),
    .loc(next_loc),
    .wait_count(wait_count),
    .cost(cost)
  );

  // ----------------------------------------
  // Cycles still owed, one counter per kind
  // ----------------------------------------
  // Loaded on accept, counted down as each cycle of that kind is picked
  generate
    for (g = 0; g < `ICT_KINDS; g = g + 1) begin : g_left
      reg [`ICT_CNTW-1:0] cnt;
      always @(posedge clk_sys) begin
        if (!rst_n) begin
          cnt <= `ICT_CNT_NONE;
        end else if (ready && start) begin
          cnt <= load_flat[g*`ICT_CNTW +: `ICT_CNTW];
        end else if (state == ST_PICK && any_left && pick_hot[g]) begin
          cnt <= cnt - `ICT_CNT_ONE;
        end
      end
      assign left_flat[g*`ICT_CNTW +: `ICT_CNTW] = cnt;
    end
  endgenerate

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      state_left <= `ICT_COST_ZERO;
      acc <= `ICT_TOT_ZERO;
      done <= 1'b0;
      busy <= 1'b0;
      cycle_kind <= `ICT_KIND_FETCH;
      cycle_start <= 1'b0;
      total_states <= `ICT_TOT_ZERO;
      elapsed_states <= `ICT_TOT_ZERO;
    end else begin
      done <= 1'b0;
      cycle_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Cycle counters load in their own loop on this same edge
          if (start) begin
            acc <= `ICT_TOT_ZERO;
            elapsed_states <= `ICT_TOT_ZERO;
            busy <= 1'b1;
            state <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (any_left) begin
            cycle_kind <= next_kind;
            cycle_start <= 1'b1;
            state_left <= cost;
            acc <= acc + cost_wide;
            state <= ST_RUN;
          end else begin
            // Completion only after every cycle has been spent
            total_states <= acc;
            done <= 1'b1;
            busy <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_RUN: begin
          // One system clock per state
          elapsed_states <= elapsed_states + `ICT_TOT_ONE;
          state_left <= state_left - `ICT_STATE_ONE;
          if (state_left == `ICT_STATE_ONE) begin
            state <= ST_PICK;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// >>> verif/ict_seq_asserts.sv
// Purpose: Port assertions for the instruction cycle timing sequencer
// Assumes: One clock, synchronous active-low reset
// Notes: Attached to every sequencer by bind
`timescale 1ns/1ps
module ict_seq_asserts (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Request
  input wire start,
  input wire [1:0] fetch_loc,
  input wire [1:0] data_loc,
  input wire [1:0] stack_loc,
  input wire [3:0] wait_count,
  // Status
  input wire ready,
  input wire done,
  input wire [2:0] cycle_kind,
  input wire cycle_start,
  input wire busy,
  input wire [8:0] total_states
);
  reg [5:0] gap;
  reg [5:0] want;
  reg seen;
  wire [1:0] loc = (cycle_kind == 3'h2) ? stack_loc : (cycle_kind > 3'h2) ? data_loc : fetch_loc;
  function [5:0] cost_of(input [2:0] k, input [1:0] l, input [3:0] m);
    case (k)
      3'h3: cost_of = (l == 2'h2) ? 6'h03 + m : 6'h03;
      3'h4: cost_of = (l == 2'h2) ? 6'h06 + {m, 1'b0} : 6'h06;
      3'h5: cost_of = 6'h01;
      default: cost_of = (l == 2'h2) ? 6'h06 + {m, 1'b0} : (l == 2'h1) ? 6'h06 : 6'h02;
    endcase
  endfunction
  // Gap since the last cycle start, checked against that cycle's cost
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      gap <= 6'h00;
      want <= 6'h00;
      seen <= 1'b0;
    end else if (cycle_start) begin
      gap <= 6'h00;
      want <= cost_of(cycle_kind, loc, wait_count);
      seen <= 1'b1;
    end else begin
      gap <= gap + 6'h01;
      seen <= seen & ~done;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_busy_blocks_ready: assert property (busy |-> !ready) else $error("ready high while busy");
  a_accept_fetch_first: assert property ((start && ready)
    |=> busy ##1 (cycle_start && cycle_kind == 3'h0)) else $error("accepted instruction did not open with a fetch");
  a_done_single_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
  a_done_ends_busy: assert property (done |-> !busy && $past(busy)) else $error("done not at end of busy");
  a_total_holds: assert property (!done |-> $stable(total_states)) else $error("total moved without done");
  a_fetch_onchip_cost: assert property ((cycle_start && cycle_kind == 3'h0 && fetch_loc == 2'h0)
    |=> !(cycle_start || done) [*2] ##1 (cycle_start || done)) else $error("on-chip fetch not two states");
  a_byte_reg_cost: assert property ((cycle_start && cycle_kind == 3'h3 && data_loc != 2'h2)
    |=> !(cycle_start || done) [*3] ##1 (cycle_start || done)) else $error("byte access not three states");
  a_cycle_cost_match: assert property (((cycle_start || done) && seen)
    |-> gap == want) else $error("cycle length differs from its cost");
  c_done: cover property (done);
  c_ext_fetch: cover property (cycle_start && fetch_loc == 2'h2);
  c_byte: cover property (cycle_start && cycle_kind == 3'h3);
endmodule
bind ict_sequencer ict_seq_asserts ict_seq_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n), .start(start),
  .fetch_loc(fetch_loc), .data_loc(data_loc), .stack_loc(stack_loc), .wait_count(wait_count), .ready(ready),
  .done(done), .cycle_kind(cycle_kind), .cycle_start(cycle_start), .busy(busy), .total_states(total_states));

// >>> verif/ict_bus_model.sv
// Purpose: Memory bus partner: supplies wait states, tallies cycles
// Assumes: Wait setting held for a whole instruction
// Notes: Tallies wrap at 8 bits; bench uses differences
`timescale 1ns/1ps
module ict_bus_model (
  input wire clk_sys,
  input wire rst_n,
  input wire cycle_start,
  input wire [2:0] cycle_kind,
  input wire [3:0] wait_cfg,
  output wire [3:0] wait_count,
  output reg [7:0] fetch_seen,
  output reg [7:0] byte_seen,
  output reg [7:0] other_seen
);
  // Same wait count on every external access
  assign wait_count = wait_cfg;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fetch_seen <= 8'h00;
      byte_seen <= 8'h00;
      other_seen <= 8'h00;
    end else if (cycle_start) begin
      fetch_seen <= fetch_seen + {7'h00, cycle_kind == 3'h0};
      byte_seen <= byte_seen + {7'h00, cycle_kind == 3'h3};
      other_seen <= other_seen + {7'h00, cycle_kind != 3'h0 && cycle_kind != 3'h3};
    end
  end
endmodule

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the instruction cycle timing sequencer
// Assumes: Stack location unused by the classes exercised
// Notes: Instructions run back to back, next start in the done cycle
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg start = 1'b0;
  reg [3:0] op_class = 4'h0;
  reg [1:0] fetch_loc = 2'h0;
  reg [1:0] data_loc = 2'h0;
  reg [3:0] wait_cfg = 4'h0;
  wire [3:0] wait_count;
  wire ready;
  wire done;
  wire [2:0] cycle_kind;
  wire cycle_start;
  wire busy;
  wire [8:0] total_states;
  wire [8:0] elapsed_states;
  wire [7:0] fetch_seen;
  wire [7:0] byte_seen;
  wire [7:0] other_seen;
  integer miscompares = 0;
  integer total_checks = 0;
  integer i;
  always #4 clk_sys = ~clk_sys;
  ict_sequencer ict_sequencer_i (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .op_class(op_class),
    .fetch_loc(fetch_loc), .data_loc(data_loc), .stack_loc(2'h0), .wait_count(wait_count), .ready(ready),
    .done(done), .cycle_kind(cycle_kind), .cycle_start(cycle_start), .busy(busy),
    .total_states(total_states), .elapsed_states(elapsed_states));
  ict_bus_model ict_bus_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .cycle_start(cycle_start),
    .cycle_kind(cycle_kind), .wait_cfg(wait_cfg), .wait_count(wait_count), .fetch_seen(fetch_seen),
    .byte_seen(byte_seen), .other_seen(other_seen));
  task print_verdict;
    begin
      if (miscompares == 0 && total_checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task check(input [8:0] got, input [8:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One instruction: length, total and cycle mix
  task run_op(input [3:0] op, input [1:0] fl, input [1:0] dl, input [3:0] m, input [8:0] tot, input [7:0] nf,
    input [7:0] nb);
    integer n;
    reg [7:0] f0;
    reg [7:0] b0;
    reg [7:0] o0;
    begin
      f0 = fetch_seen;
      b0 = byte_seen;
      o0 = other_seen;
      op_class = op;
      fetch_loc = fl;
      data_loc = dl;
      wait_cfg = m;
      start = 1'b1;
      @(posedge clk_sys);
      #1 start = 1'b0;
      check({8'h00, busy}, 9'h001);
      check({8'h00, ready}, 9'h000);
      n = 0;
      while (done !== 1'b1 && n < 400) begin
        @(posedge clk_sys);
        #1 n = n + 1;
      end
      if (n >= 400) begin
        miscompares = miscompares + 1;
        print_verdict;
      end else begin
        check(n[8:0], tot + {1'b0, nf} + {1'b0, nb} + 9'h001);
        check(total_states, tot);
        check(elapsed_states, tot);
        check({7'h00, busy, ready}, 9'h001);
        check({1'b0, fetch_seen - f0}, {1'b0, nf});
        check({1'b0, byte_seen - b0}, {1'b0, nb});
        check({1'b0, other_seen - o0}, 9'h000);
      end
    end
  endtask
  task s_single_fetch;
    begin
      for (i = 0; i < 14; i = i + 1) begin
        if (i != 10 && i != 11 && i != 13) begin
          run_op(i[3:0], {1'b0, i[0]}, 2'h1, 4'h0, i[0] ? 9'h006 : 9'h002, 8'h01, 8'h00);
        end
      end
    end
  endtask
  task s_branch;
    begin
      run_op(4'hb, 2'h0, 2'h1, 4'h3, 9'h004, 8'h02, 8'h00);
      run_op(4'hb, 2'h2, 2'h1, 4'h3, 9'h018, 8'h02, 8'h00);
    end
  endtask
  task s_bit_mem;
    begin
      run_op(4'ha, 2'h0, 2'h2, 4'h2, 9'h009, 8'h02, 8'h01);
      run_op(4'ha, 2'h0, 2'h0, 4'h2, 9'h007, 8'h02, 8'h01);
      run_op(4'hd, 2'h1, 2'h1, 4'h0, 9'h012, 8'h02, 8'h02);
      run_op(4'hd, 2'h2, 2'h2, 4'h5, 9'h030, 8'h02, 8'h02);
    end
  endtask
  // Reset in the middle of an instruction, then a clean instruction after it
  task s_reset_mid;
    begin
      op_class = 4'hd;
      fetch_loc = 2'h2;
      data_loc = 2'h2;
      wait_cfg = 4'h5;
      start = 1'b1;
      @(posedge clk_sys);
      #1 start = 1'b0;
      repeat (10) @(posedge clk_sys);
      #1 rst_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 check({busy, ready, done, cycle_start, cycle_kind, 2'h0}, 9'h080);
      check(total_states, 9'h000);
      check(elapsed_states, 9'h000);
      rst_n = 1'b1;
      run_op(4'hb, 2'h1, 2'h1, 4'h0, 9'h00c, 8'h02, 8'h00);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    s_single_fetch;
    s_branch;
    s_bit_mem;
    s_reset_mid;
    print_verdict;
  end
endmodule
